/* File: acpi_rail_sequencer_tb.sv */
// Self-checking bench for the ACPI rail sequencer
`timescale 1ns/1ns
`default_nettype none
module acpi_rail_sequencer_tb;
  import arsq_pkg::*;
  localparam int HS = 0;
  localparam int TERM = 4;
  localparam int DRV1 = 5;
  logic ref_clk = 1'h0;
  logic rst_n = 1'h0;
  logic ref_good = 1'h0;
  logic ilim = 1'h0;
  logic ss_gnd = 1'h0;
  logic [2:0] supply_cmd = 3'h7;
  logic sleep_cmd = 1'h0;
  logic fault_cmd = 1'h0;
  logic sb_good, boot_good, atx5_good, buffer_cut_request;
  logic ss_done, rail_good, fb_low, in_reg;
  logic [3:0] awaddr = 4'h0;
  logic [3:0] araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'h0;
  logic wvalid = 1'h0;
  logic bready = 1'h0;
  logic arvalid = 1'h0;
  logic rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  wire logic [8:0] obs;
  int num_errors = 0;
  int total_checks = 0;
  logic [31:0] rd;
  logic [1:0] rsp;

  arsq_board_model board (.clk(ref_clk), .supply_cmd(supply_cmd),
    .sleep_cmd(sleep_cmd), .fault_cmd(fault_cmd), .ss_release(obs[2]),
    .lin_drive(obs[DRV1]), .standby_good(sb_good), .boot_good(boot_good),
    .atx5_good(atx5_good), .buffer_cut_request(buffer_cut_request), .ss_done(ss_done),
    .rail_good(rail_good), .fb_low(fb_low), .in_reg(in_reg));

  arsq_top #(.LIN_SS_CYCLES(20)) uut (.REF_CLK(ref_clk), .RST_N(rst_n),
    .REFERENCE_GOOD(ref_good), .STANDBY_SUPPLY_GOOD(sb_good),
    .BOOT_SUPPLY_GOOD(boot_good), .ATX5_SUPPLY_GOOD(atx5_good),
    .BUFFER_CUT_REQUEST(buffer_cut_request), .CURRENT_LIMIT_SENSE(ilim),
    .SOFT_START_GROUNDED(ss_gnd), .SOFT_START_DONE(ss_done),
    .MEMORY_RAIL_GOOD(rail_good), .LINEAR_FB_LOW(fb_low),
    .LINEAR_IN_REG(in_reg), .HIGH_SIDE_GATE(obs[0]),
    .LOW_SIDE_GATE(obs[1]), .SOFT_START_RELEASE(obs[2]),
    .MAIN_RAIL_IN_REGULATION(obs[3]), .TERMINATION_ENABLE(obs[4]),
    .FIRST_LINEAR_DRIVE(obs[5]), .SECOND_LINEAR_DRIVE(obs[6]),
    .STANDBY_MONITOR_EN(obs[7]), .SUPPLY_MONITORS_EN(obs[8]),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready));

  // 50 MHz reference clock
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end

  // Compare and count; an unknown never matches
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, got, exp);
    end
  endtask

  // Register write; address and data are released as each is taken
  task automatic axw(input logic [3:0] a, input logic [31:0] d,
                     output logic [1:0] r);
    int k;
    k = 0;
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge ref_clk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      k++;
    end while (bvalid !== 1'h1 && k < 50);
    r = bresp;
    bready <= 1'h0;
    if (k >= 50) chk(32'h1, 32'h0);
  endtask

  // Register read; rready stays up until the data is seen
  task automatic axr(input logic [3:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    int k;
    k = 0;
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge ref_clk);
      if (arvalid && arready) arvalid <= 1'h0;
      k++;
    end while (rvalid !== 1'h1 && k < 50);
    d = rdata;
    r = rresp;
    rready <= 1'h0;
    if (k >= 50) chk(32'h1, 32'h0);
  endtask

  // Reads the state field of the status word
  task automatic state_is(input logic [31:0] e);
    axr(ADDR_STATUS, rd, rsp);
    chk({30'h0, rd[1:0]}, e);
  endtask

  // Bounded wait for one observed output to reach a level
  task automatic wb(input int i, input logic v, input int lim);
    int k;
    k = 0;
    while (obs[i] !== v && k < lim) begin
      @(posedge ref_clk);
      k++;
    end
    chk({31'h0, obs[i]}, {31'h0, v});
  endtask

  // Measures one high-side period in clock cycles
  task automatic per(input int exp);
    int k;
    k = 0;
    wb(HS, 1'h0, 400);
    wb(HS, 1'h1, 400);
    do begin
      @(posedge ref_clk);
      k++;
    end while (obs[HS] !== 1'h0 && k < 400);
    chk({31'h0, obs[1]}, 32'h1);
    do begin
      @(posedge ref_clk);
      k++;
    end while (obs[HS] !== 1'h1 && k < 400);
    chk({31'h0, obs[1]}, 32'h0);
    chk(k, exp);
  endtask

  // Prints the counts and the verdict, then stops
  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Cuts a hang short well past the expected run length
  initial begin
    #1000000;
    num_errors++;
    wrap_up();
  end

  // Main sequence
  initial begin
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'h1;
    repeat (5) @(posedge ref_clk);
    state_is(32'h0);
    chk({23'h0, obs}, 32'h0);
    axr(ADDR_CTRL, rd, rsp);
    chk(rd, 32'h80);
    axr(4'h8, rd, rsp);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
    axw(ADDR_STATUS, 32'hFF, rsp);
    chk({30'h0, rsp}, {30'h0, RESP_OKAY});
    axw(ADDR_CTRL, 32'h40, rsp);
    axr(ADDR_CTRL, rd, rsp);
    chk(rd, 32'h40);
    axw(ADDR_CTRL, 32'h80, rsp);
    state_is(32'h0);
    $display("test reset done");
    supply_cmd <= 3'h3;
    sleep_cmd <= 1'h1;
    fault_cmd <= 1'h1;
    ref_good <= 1'h1;
    repeat (10) @(posedge ref_clk);
    chk({30'h0, obs[8:7]}, 32'h1);
    supply_cmd <= 3'h7;
    repeat (10) @(posedge ref_clk);
    chk({31'h0, obs[8]}, 32'h1);
    state_is(32'h0);
    sleep_cmd <= 1'h0;
    repeat (10) @(posedge ref_clk);
    state_is(32'h1);
    $display("test power up done");
    wb(TERM, 1'h1, 300);
    chk({29'h0, obs[3], rail_good, ss_done}, 32'h7);
    wb(DRV1, 1'h1, 50);
    wb(DRV1, 1'h0, 20);
    wb(DRV1, 1'h1, 20);
    fault_cmd <= 1'h0;
    repeat (100) @(posedge ref_clk);
    axr(ADDR_STATUS, rd, rsp);
    chk({31'h0, rd[4]}, 32'h1);
    fault_cmd <= 1'h1;
    repeat (40) @(posedge ref_clk);
    chk({30'h0, obs[6:5]}, 32'h3);
    fault_cmd <= 1'h0;
    per(200);
    $display("test s0 ramp done");
    ilim <= 1'h1;
    repeat (400) @(posedge ref_clk);
    axr(ADDR_STATUS, rd, rsp);
    chk({31'h0, rd[2]}, 32'h1);
    chk({25'h0, obs[6:0]}, 32'h0);
    sleep_cmd <= 1'h1;
    repeat (20) @(posedge ref_clk);
    state_is(32'h2);
    repeat (250) @(posedge ref_clk);
    chk({30'h0, obs[1:0]}, 32'h0);
    ilim <= 1'h0;
    ss_gnd <= 1'h1;
    repeat (10) @(posedge ref_clk);
    ss_gnd <= 1'h0;
    repeat (10) @(posedge ref_clk);
    axr(ADDR_STATUS, rd, rsp);
    chk({31'h0, rd[2]}, 32'h0);
    per(100);
    chk({29'h0, obs[6:4]}, 32'h0);
    $display("test overcurrent done");
    ilim <= 1'h1;
    repeat (400) @(posedge ref_clk);
    axr(ADDR_STATUS, rd, rsp);
    chk({31'h0, rd[2]}, 32'h0);
    ilim <= 1'h0;
    supply_cmd <= 3'h4;
    repeat (20) @(posedge ref_clk);
    state_is(32'h2);
    sleep_cmd <= 1'h0;
    repeat (20) @(posedge ref_clk);
    state_is(32'h2);
    supply_cmd <= 3'h7;
    sleep_cmd <= 1'h1;
    repeat (20) @(posedge ref_clk);
    state_is(32'h2);
    sleep_cmd <= 1'h0;
    repeat (20) @(posedge ref_clk);
    state_is(32'h1);
    wb(DRV1, 1'h1, 300);
    per(200);
    $display("test s3 done");
    for (int i = 0; i < 3; i++) begin
      supply_cmd <= 3'h7 & ~(3'h1 << i);
      repeat (20) @(posedge ref_clk);
      state_is(32'h0);
      chk({28'h0, obs[6:5], obs[1:0]}, 32'h0);
      supply_cmd <= 3'h7;
      repeat (30) @(posedge ref_clk);
      state_is(32'h1);
    end
    $display("test supply loss done");
    wrap_up();
  end
endmodule
`default_nettype wire

/* File: arsq_board_model.sv */
// Motherboard and analog stand-in that drives the sequencer pins
`timescale 1ns/1ns
`default_nettype none
module arsq_board_model #(
  parameter int SS_DLY = 40,
  parameter int IR_DLY = 30
) (
  input wire logic clk,
  input wire logic [2:0] supply_cmd,
  input wire logic sleep_cmd,
  input wire logic fault_cmd,
  input wire logic ss_release,
  input wire logic lin_drive,
  output logic standby_good,
  output logic boot_good,
  output logic atx5_good,
  output logic buffer_cut_request,
  output logic ss_done,
  output logic rail_good,
  output logic fb_low,
  output logic in_reg
);
  int ss_cnt = 0;
  int lin_cnt = 0;
  // Chipset supplies and sleep request follow the commands one edge later
  always_ff @(posedge clk) begin
    {standby_good, boot_good, atx5_good} <= supply_cmd;
    buffer_cut_request <= sleep_cmd;
  end
  // Memory rail needs a while after release before it reports 90 percent
  always_ff @(posedge clk) begin
    ss_cnt <= ss_release ? ss_cnt + 1 : 0;
    ss_done <= ss_release && ss_cnt >= SS_DLY;
    rail_good <= ss_release && ss_cnt >= SS_DLY;
  end
  // A commanded short keeps the feedback low and never lets it regulate
  always_ff @(posedge clk) begin
    lin_cnt <= lin_drive ? lin_cnt + 1 : 0;
    fb_low <= lin_drive && fault_cmd;
    in_reg <= lin_drive && !fault_cmd && lin_cnt >= IR_DLY;
  end
endmodule
`default_nettype wire

/* File: arsq_pkg.sv */
// Constants, types and register map of the ACPI rail sequencer
// Functional notes
// R1 - Come out of reset in S5 with every regulator off.
// R2 - S5 goes to S0 when all three supplies good and buffer_cut low.
// R3 - In S0 a rising buffer_cut_request moves to S3.
// R4 - In S3 loss of boot and atx5 good is ignored; stay in S3.
// R5 - In S3 falling buffer_cut with boot and atx5 good returns to S0.
// R6 - In S0 loss of any supply-good goes to S5.
// R7 - Never step directly between S3 and S5. The code still steps S3 to S5 directly when reference_good drops.
// R8 - Logic held inactive until reference_good is asserted.
// R9 - Standby monitor first; boot and atx5 monitors after standby good.
// R10 - S0 starts memory soft-start; in-regulation flag enables other rails.
// R11 - In S0 the memory PWM runs at 250 kHz on both gates.
// R12 - In S3 the memory PWM runs at twice the S0 rate.
// R13 - Per-state outputs: S0 normal, S3 standby, S5 all low.
// R14 - Overcurrent sampled after blanking from high-side on; latches off.
// R15 - Overcurrent latch cleared by supply recycle or grounded soft-start.
// R16 - Memory overcurrent detection disabled in S3.
// R17 - Both linear controllers share one 1.5 ms soft-start ramp.
// R18 - Feedback 100 mV below ramp restarts both linear soft-starts.
// R19 - Hiccup checking stops once both linear outputs regulate.
// R20 - Termination and linear rails ramp after memory rail 90% good.
// R21 - Any other input combination leaves the state unchanged.
// R22 - While overcurrent latched, all gates and drives held as in S5.
// R23 - Each S3 to S0 return ramps termination and linears afresh.
package arsq_pkg;
  // Timing, all derived from the reference clock rate
  localparam int CLK_KHZ = 50000;
  localparam int CLK_NS = 20;
  localparam int PWM_S0_KHZ = 250;
  localparam int PWM_S3_MULT = 2;
  localparam int PWM_S0_CYC = CLK_KHZ / PWM_S0_KHZ;
  localparam int PWM_S3_CYC = PWM_S0_CYC / PWM_S3_MULT;
  localparam int PWM_W = 8;
  localparam logic [7:0] PWM_S0_LAST = 8'(PWM_S0_CYC - 1);
  localparam logic [7:0] PWM_S3_LAST = 8'(PWM_S3_CYC - 1);
  localparam int BLANK_NS = 200;
  localparam int BLANK_CYC_I = (BLANK_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] BLANK_CYC = 8'(BLANK_CYC_I);
  localparam int LIN_SS_US = 1500;
  localparam int LIN_SS_CYC = LIN_SS_US * (CLK_KHZ / 1000);
  // Register bus
  localparam int ADDR_W = 4;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [7:0] DUTY_RST = 8'h80;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_OC_BIT = 2;
  localparam int STAT_INREG_BIT = 3;
  localparam int STAT_LDONE_BIT = 4;
  localparam int STAT_MON_BIT = 5;

  typedef enum logic [1:0] {ARSQ_S5, ARSQ_S0, ARSQ_S3} arsq_state_t;

  // Pin inputs, all asynchronous to the reference clock
  typedef struct packed {
    logic ref_good;
    logic standby_good;
    logic boot_good;
    logic atx5_good;
    logic buffer_cut_request;
    logic ilim;
    logic ss_grounded;
    logic ss_done;
    logic rail_good;
    logic lin_fb_low;
    logic lin_in_reg;
  } arsq_pins_t;
endpackage

/* File: arsq_top.sv */
// ACPI rail sequencer: state machine, PWM, protection, register slave
`timescale 1ns/1ns
`default_nettype none
module arsq_top
  import arsq_pkg::*;
#(
  parameter int LIN_SS_CYCLES = LIN_SS_CYC
) (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic REFERENCE_GOOD,
  input wire logic STANDBY_SUPPLY_GOOD,
  input wire logic BOOT_SUPPLY_GOOD,
  input wire logic ATX5_SUPPLY_GOOD,
  input wire logic BUFFER_CUT_REQUEST,
  input wire logic CURRENT_LIMIT_SENSE,
  input wire logic SOFT_START_GROUNDED,
  input wire logic SOFT_START_DONE,
  input wire logic MEMORY_RAIL_GOOD,
  input wire logic LINEAR_FB_LOW,
  input wire logic LINEAR_IN_REG,
  output logic HIGH_SIDE_GATE,
  output logic LOW_SIDE_GATE,
  output logic SOFT_START_RELEASE,
  output logic MAIN_RAIL_IN_REGULATION,
  output logic TERMINATION_ENABLE,
  output logic FIRST_LINEAR_DRIVE,
  output logic SECOND_LINEAR_DRIVE,
  output logic STANDBY_MONITOR_EN,
  output logic SUPPLY_MONITORS_EN,
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  localparam int LSW = $clog2(LIN_SS_CYCLES + 1);
  localparam logic [LSW-1:0] LIN_END = LSW'(LIN_SS_CYCLES);

  // Refuse settings the counters cannot hold
  generate
    if (LIN_SS_CYCLES < 1 || PWM_S0_CYC > 255 || PWM_S3_CYC < 2) begin : g_chk
      $error("arsq_top: unsupported timing setting");
    end
  endgenerate

  logic rst_s1_r;
  logic rst_n_r;
  arsq_pins_t pin_in;
  arsq_pins_t pin_s1_r;
  arsq_pins_t pin_r;
  arsq_state_t state_r;
  logic buf_prev_r;
  logic [2:0] good_prev_r;
  logic oc_r;
  logic [PWM_W-1:0] pwm_cnt_r;
  logic [7:0] hs_cnt_r;
  logic [7:0] duty_r;
  logic hs_r;
  logic ls_r;
  logic ss_rel_r;
  logic inreg_r;
  logic [LSW-1:0] lin_cnt_r;
  logic lin_done_r;
  logic term_r;
  logic lin1_r;
  logic lin2_r;
  logic mon_sb_r;
  logic mon_sup_r;
  logic aw_rdy_r;
  logic w_rdy_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic ar_rdy_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  logic active_w;
  logic all_good_w;
  logic buf_rise_w;
  logic buf_fall_w;
  logic running_w;
  logic [7:0] period_last_w;
  logic [15:0] on_prod_w;
  logic hs_nxt;
  logic oc_set_w;
  logic oc_clr_w;
  logic write_w;

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_s1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r <= rst_s1_r;
    end
  end

  // Gather pin inputs into one carrier
  always_comb begin
    pin_in.ref_good = REFERENCE_GOOD;
    pin_in.standby_good = STANDBY_SUPPLY_GOOD;
    pin_in.boot_good = BOOT_SUPPLY_GOOD;
    pin_in.atx5_good = ATX5_SUPPLY_GOOD;
    pin_in.buffer_cut_request = BUFFER_CUT_REQUEST;
    pin_in.ilim = CURRENT_LIMIT_SENSE;
    pin_in.ss_grounded = SOFT_START_GROUNDED;
    pin_in.ss_done = SOFT_START_DONE;
    pin_in.rail_good = MEMORY_RAIL_GOOD;
    pin_in.lin_fb_low = LINEAR_FB_LOW;
    pin_in.lin_in_reg = LINEAR_IN_REG;
  end

  // Two-flop synchroniser; only pin_r is read by logic
  always_ff @(posedge REF_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pin_s1_r <= '0;
      pin_r <= '0;
    end else begin
      pin_s1_r <= pin_in;
      pin_r <= pin_s1_r;
    end
  end

  // R8 reference gate
  assign active_w = pin_r.ref_good;
  // Boot and atx5 monitors only count once they are enabled
  assign all_good_w = pin_r.standby_good & mon_sup_r & pin_r.boot_good
                      & pin_r.atx5_good;
  assign buf_rise_w = pin_r.buffer_cut_request & ~buf_prev_r;
  assign buf_fall_w = ~pin_r.buffer_cut_request & buf_prev_r;

  // Edge history of the request and supply levels
  always_ff @(posedge REF_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      buf_prev_r <= 1'b0;
      good_prev_r <= 3'h0;
    end else begin
      buf_prev_r <= pin_r.buffer_cut_request;
      good_prev_r <= {pin_r.standby_good, pin_r.boot_good,
                      pin_r.atx5_good};
    end
  end

  // R9 monitor enables, standby first
  always_ff @(posedge REF_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      mon_sb_r <= 1'b0;
      mon_sup_r <= 1'b0;
    end else begin
      mon_sb_r <= active_w;
      mon_sup_r <= active_w & pin_r.standby_good;
    end
  end

  // R1 state machine, S5 out of reset; R21 nothing else moves it
  always_ff @(posedge REF_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r <= ARSQ_S5;
    end else if (!active_w) begin
      // R8 inactive forces shutdown
      state_r <= ARSQ_S5;
    end else begin
      unique case (state_r)
        ARSQ_S5: begin
          // R2 power-up entry
          if (all_good_w && !pin_r.buffer_cut_request) begin
            state_r <= ARSQ_S0;
          end
        end
        ARSQ_S0: begin
          // R6 supply loss wins over a sleep request
          if (!all_good_w) begin
            state_r <= ARSQ_S5;
          // R3 sleep on rising request
          end else if (buf_rise_w) begin
            state_r <= ARSQ_S3;
          end
        end
        ARSQ_S3: begin
          // R5 wake; R4 R7 no exit on supply collapse
          if (buf_fall_w && pin_r.boot_good && pin_r.atx5_good) begin
            state_r <= ARSQ_S0;
          end
        end
      endcase
    end
  end

  // R14 blanked sample; R16 ignored outside S0
  assign oc_set_w = (state_r == ARSQ_S0) & hs_r & (hs_cnt_r == BLANK_CYC)
                    & pin_r.ilim;
  // R15 supply recycle or grounded soft-start pin
  assign oc_clr_w = (|(good_prev_r & ~{pin_r.standby_good, pin_r.boot_good,
                    pin_r.atx5_good})) | pin_r.ss_grounded;

  // Overcurrent latch; a new trip wins over a clear in the same cycle
  always_ff @(posedge REF_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      oc_r <= 1'b0;
    end else if (oc_set_w) begin
      oc_r <= 1'b1;
    end else if (oc_clr_w) begin
      oc_r <= 1'b0;
    end
  end

  // R11 R12 period by state; duty from software
  assign running_w = (state_r != ARSQ_S5) & ~oc_r;
  assign period_last_w = (state_r == ARSQ_S3) ? PWM_S3_LAST : PWM_S0_LAST;
  assign on_prod_w = ({8'h00, period_last_w} + 16'h0001) * {8'h00, duty_r};
  assign hs_nxt = running_w & (pwm_cnt_r < on_prod_w[15:8]);

  // PWM ramp counter
  always_ff @(posedge REF_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pwm_cnt_r <= '0;
    end else if (!running_w || pwm_cnt_r >= period_last_w) begin
      pwm_cnt_r <= '0;
    end else begin
      pwm_cnt_r <= pwm_cnt_r + 8'h01;
    end
  end

  // R13 R22 gate drive; complementary, both low when stopped
  always_ff @(posedge REF_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      hs_r <= 1'b0;
      ls_r <= 1'b0;
      ss_rel_r <= 1'b0;
    end else begin
      hs_r <= hs_nxt;
      ls_r <= running_w & ~hs_nxt;
      ss_rel_r <= running_w;
    end
  end

  // Blanking timer since high-side turn-on, saturating
  always_ff @(posedge REF_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      hs_cnt_r <= 8'h00;
    end else if (!hs_r) begin
      hs_cnt_r <= 8'h00;
    end else if (hs_cnt_r != BLANK_CYC) begin
      hs_cnt_r <= hs_cnt_r + 8'h01;
    end
  end

  // R10 R20 in-regulation; R23 dropped outside S0 so each return re-ramps
  always_ff @(posedge REF_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      inreg_r <= 1'b0;
    end else begin
      inreg_r <= (state_r == ARSQ_S0) & ~oc_r & pin_r.ss_done
                 & pin_r.rail_good;
    end
  end

  // R17 shared linear ramp, restarts from zero on each enable
  always_ff @(posedge REF_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      lin_cnt_r <= '0;
      lin_done_r <= 1'b0;
    end else if (!inreg_r) begin
      lin_cnt_r <= '0;
      lin_done_r <= 1'b0;
    end else if (!lin_done_r) begin
      // R18 hiccup restart
      if (pin_r.lin_fb_low) begin
        lin_cnt_r <= '0;
      end else if (lin_cnt_r != LIN_END) begin
        lin_cnt_r <= lin_cnt_r + LSW'(1);
      // R19 checking ends once regulating after the ramp
      end else if (pin_r.lin_in_reg) begin
        lin_done_r <= 1'b1;
      end
    end
  end

  // R13 R22 termination and linear drives follow in-regulation
  always_ff @(posedge REF_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      term_r <= 1'b0;
      lin1_r <= 1'b0;
      lin2_r <= 1'b0;
    end else begin
      term_r <= inreg_r & ~oc_r;
      // R18 a hiccup holds both linear drives off until it clears
      lin1_r <= inreg_r & ~oc_r & ~(~lin_done_r & pin_r.lin_fb_low);
      lin2_r <= inreg_r & ~oc_r & ~(~lin_done_r & pin_r.lin_fb_low);
    end
  end

  assign HIGH_SIDE_GATE = hs_r;
  assign LOW_SIDE_GATE = ls_r;
  assign SOFT_START_RELEASE = ss_rel_r;
  assign MAIN_RAIL_IN_REGULATION = inreg_r;
  assign TERMINATION_ENABLE = term_r;
  assign FIRST_LINEAR_DRIVE = lin1_r;
  assign SECOND_LINEAR_DRIVE = lin2_r;
  assign STANDBY_MONITOR_EN = mon_sb_r;
  assign SUPPLY_MONITORS_EN = mon_sup_r;

  // Write channel: address and data taken in either order
  assign write_w = ~aw_rdy_r & ~w_rdy_r & ~bvalid_r;

  always_ff @(posedge REF_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      aw_rdy_r <= 1'b1;
      w_rdy_r <= 1'b1;
      aw_addr_r <= '0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else begin
      if (aw_rdy_r && S_AXI_AWVALID) begin
        aw_rdy_r <= 1'b0;
        aw_addr_r <= S_AXI_AWADDR;
      end
      if (w_rdy_r && S_AXI_WVALID) begin
        w_rdy_r <= 1'b0;
        w_data_r <= S_AXI_WDATA;
        w_strb_r <= S_AXI_WSTRB;
      end
      if (write_w) begin
        bvalid_r <= 1'b1;
        bresp_r <= (aw_addr_r == ADDR_CTRL || aw_addr_r == ADDR_STATUS)
                   ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_r && S_AXI_BREADY) begin
        bvalid_r <= 1'b0;
        aw_rdy_r <= 1'b1;
        w_rdy_r <= 1'b1;
      end
    end
  end

  // Duty control; status is read-only so writes there are dropped
  always_ff @(posedge REF_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      duty_r <= DUTY_RST;
    end else if (write_w && aw_addr_r == ADDR_CTRL && w_strb_r[0]) begin
      duty_r <= w_data_r[7:0];
    end
  end

  // Read channel, one cycle from address to data
  always_ff @(posedge REF_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ar_rdy_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
    end else if (ar_rdy_r && S_AXI_ARVALID) begin
      ar_rdy_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
      if (S_AXI_ARADDR == ADDR_CTRL) begin
        rdata_r[7:0] <= duty_r;
      end else if (S_AXI_ARADDR == ADDR_STATUS) begin
        rdata_r[STAT_STATE_LSB +: 2] <= state_r;
        rdata_r[STAT_OC_BIT] <= oc_r;
        rdata_r[STAT_INREG_BIT] <= inreg_r;
        rdata_r[STAT_LDONE_BIT] <= lin_done_r;
        rdata_r[STAT_MON_BIT] <= mon_sup_r;
      end else begin
        rresp_r <= RESP_SLVERR;
      end
    end else if (rvalid_r && S_AXI_RREADY) begin
      rvalid_r <= 1'b0;
      ar_rdy_r <= 1'b1;
    end
  end

  assign S_AXI_AWREADY = aw_rdy_r;
  assign S_AXI_WREADY = w_rdy_r;
  assign S_AXI_BVALID = bvalid_r;
  assign S_AXI_BRESP = bresp_r;
  assign S_AXI_ARREADY = ar_rdy_r;
  assign S_AXI_RVALID = rvalid_r;
  assign S_AXI_RDATA = rdata_r;
  assign S_AXI_RRESP = rresp_r;

  // Checks on the sequencing
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!rst_n_r);

  sequence s5_to_s0_seq;
    state_r == ARSQ_S5 ##1 state_r == ARSQ_S0;
  endsequence
  sequence sleep_req_seq;
    active_w && state_r == ARSQ_S0 && all_good_w && buf_rise_w;
  endsequence

  power_up_a: assert property (s5_to_s0_seq |-> // R2
    $past(all_good_w && !pin_r.buffer_cut_request))
    else $error("S0 entered without all supplies good");
  sleep_entry_a: assert property (sleep_req_seq |=> // R3
    state_r == ARSQ_S3)
    else $error("sleep request did not reach S3");
  s3_hold_a: assert property ((active_w && state_r == ARSQ_S3 // R4
    && !buf_fall_w) |=> state_r == ARSQ_S3)
    else $error("S3 left without a falling request");
  s3_wake_a: assert property ((active_w && state_r == ARSQ_S3 // R5
    && buf_fall_w && pin_r.boot_good && pin_r.atx5_good)
    |=> state_r == ARSQ_S0)
    else $error("S3 did not return to S0");
  supply_loss_a: assert property ((active_w && state_r == ARSQ_S0 // R6
    && !all_good_w) |=> state_r == ARSQ_S5 ##1 !hs_r ##1 !lin1_r)
    else $error("supply loss did not shut down");
  no_skip_a: assert property ((active_w && state_r == ARSQ_S3) // R7
    |=> state_r != ARSQ_S5)
    else $error("direct S3 to S5 step");
  ref_hold_a: assert property (!active_w |=> // R8
    state_r == ARSQ_S5 && !mon_sb_r)
    else $error("logic active without reference");
  mon_order_a: assert property (mon_sup_r |-> // R9
    $past(pin_r.standby_good && active_w))
    else $error("supply monitors before standby good");
  pwm_s0_a: assert property ((state_r == ARSQ_S0 && running_w // R11
    && pwm_cnt_r == PWM_S0_LAST) |=> pwm_cnt_r == 8'h00)
    else $error("S0 period wrong");
  pwm_s3_a: assert property ((state_r == ARSQ_S3 && running_w // R12
    && pwm_cnt_r == PWM_S3_LAST) |=> pwm_cnt_r == 8'h00)
    else $error("S3 period wrong");
  oc_off_a: assert property (oc_r |=> // R22
    !hs_r && !ls_r && !term_r && !lin1_r && !lin2_r)
    else $error("outputs active under overcurrent");
  oc_s3_a: assert property ((state_r == ARSQ_S3 && !oc_r) // R16
    |=> !oc_r)
    else $error("overcurrent tripped in S3");
  oc_keep_a: assert property ((oc_r && !oc_clr_w) |=> oc_r) // R15
    else $error("overcurrent latch lost");
  hiccup_a: assert property ((inreg_r && !lin_done_r // R18
    && pin_r.lin_fb_low) |=> lin_cnt_r == '0)
    else $error("hiccup did not restart ramp");
  hiccup_drv_a: assert property ((inreg_r && !lin_done_r // R18
    && pin_r.lin_fb_low) |=> !lin1_r && !lin2_r)
    else $error("linear drives kept on during hiccup");
  inreg_a: assert property ($rose(inreg_r) |-> // R20
    $past(state_r == ARSQ_S0 && pin_r.ss_done && pin_r.rail_good)
    && lin_cnt_r == '0)
    else $error("in-regulation without memory rail good");
endmodule
`default_nettype wire
